//--- core/dah_ack_core.sv
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Enable command turns handshake on, answers itself
// - Handshake disabled after any reset
// - Read answers after bus cycle, data ready
// - Write answers after data in, bus done
// - Background answers on entry to background
// - Go answers on leaving background
// - Go-until answers at next background entry
// - Single step answers on background re-entry
// - Tagged run never answers
// - Sync cancels pending run-control answer
module dah_ack_core
(
	input  wire logic       CLOCK,       // Core clock, 40 MHz
	input  wire logic       RESET,       // Async, active high
	input  wire logic       CMD_VALID,   // One-cycle command strobe
	input  wire logic [3:0] CMD_CODE,    // Decoded command
	input  wire logic       BUS_DONE,    // Internal bus cycle finished
	input  wire logic       CPU_HALTED,  // Processor in background mode
	input  wire logic       PIN_IN,      // debug_wire_pin level (unused)
	output var  logic       PIN_OUT,     // Level driven on pin
	output var  logic       PIN_OE,      // High while driving pin
	output var  logic       ACK_ENABLED, // Handshake state
	output var  logic       ACK_PENDING  // Answer outstanding
);

	// ==========================================================
	// State
	// ==========================================================
	logic                    ack_en_q;    // Handshake on
	dah_pkg::dah_state_t     state_q;     // Current wait
	dah_pkg::dah_state_t     state_d;     // Next wait
	logic [4:0]              cnt_q;       // Pulse cycle counter
	logic                    halted_q;    // Background, last cycle
	logic                    cmd_ok;      // Command worth decoding
	dah_pkg::dah_cmd_t       cmd;         // Typed command
	logic                    enter_halt;  // Background entry edge
	logic                    leave_halt;  // Background exit edge

	assign cmd        = dah_pkg::dah_cmd_t'(CMD_CODE);
	assign cmd_ok     = CMD_VALID;
	assign enter_halt = CPU_HALTED & ~halted_q;
	assign leave_halt = ~CPU_HALTED & halted_q;

	// ==========================================================
	// Command decode helper
	// ==========================================================
	// True when a command of the given kind is taken this cycle
	function automatic logic cmd_is(
		input logic              valid, // Strobe
		input dah_pkg::dah_cmd_t code,  // Code presented
		input dah_pkg::dah_cmd_t kind   // Code looked for
	);
		cmd_is = valid && (code == kind);
	endfunction

	// ==========================================================
	// Background edge tracker
	// ==========================================================
	// Reset value 1 so no false entry edge appears straight after reset
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
			halted_q <= 1'b1;
		else
			halted_q <= CPU_HALTED;
	end

	// ==========================================================
	// Handshake enable flag
	// ==========================================================
	// Host keeps its own worst-case waits while this is low
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
			ack_en_q <= 1'b0;
		else if (cmd_is(cmd_ok, cmd, dah_pkg::CMD_ACK_ON))
			ack_en_q <= 1'b1;
		else if (cmd_is(cmd_ok, cmd, dah_pkg::CMD_ACK_OFF))
			ack_en_q <= 1'b0;
	end

	// ==========================================================
	// Next-wait decode
	// ==========================================================
	// A new command replaces any pending wait (not a running pulse); the
	// host is not allowed to overlap commands, so this only
	// matters for sync, which must drop the old answer.
	always_comb
	begin
		state_d = state_q;
		if (state_q == dah_pkg::WAIT_PULSE)
		begin
			// Pulse runs to completion
			if (cnt_q == dah_pkg::ACK_CNT_LAST)
				state_d = dah_pkg::WAIT_IDLE;
		end
		else if (cmd_ok)
		begin
			case (cmd)
				dah_pkg::CMD_ACK_ON:
					// Handshake supported, so enable is always answered
					state_d = dah_pkg::WAIT_PULSE;
				dah_pkg::CMD_READ,
				dah_pkg::CMD_WRITE:
					// Write data already shifted in by strobe time
					state_d = ack_en_q ? dah_pkg::WAIT_BUS
						: dah_pkg::WAIT_IDLE;
				dah_pkg::CMD_BACKGROUND,
				dah_pkg::CMD_GO_UNTIL,
				dah_pkg::CMD_STEP:
					state_d = ack_en_q ? dah_pkg::WAIT_HALT
						: dah_pkg::WAIT_IDLE;
				dah_pkg::CMD_GO:
					state_d = ack_en_q ? dah_pkg::WAIT_RESUME
						: dah_pkg::WAIT_IDLE;
				dah_pkg::CMD_TAG_RUN:
					state_d = dah_pkg::WAIT_IDLE;
				dah_pkg::CMD_SYNC:
					state_d = dah_pkg::WAIT_IDLE;
				default:
					state_d = dah_pkg::WAIT_IDLE;
			endcase
		end
		else
		begin
			case (state_q)
				dah_pkg::WAIT_BUS:
					if (BUS_DONE)
						state_d = dah_pkg::WAIT_PULSE;
				dah_pkg::WAIT_HALT:
					if (enter_halt)
						state_d = dah_pkg::WAIT_PULSE;
				dah_pkg::WAIT_RESUME:
					if (leave_halt)
						state_d = dah_pkg::WAIT_PULSE;
				default:
					state_d = state_q;
			endcase
		end
		// Handshake switched off: drop anything not yet driving
		if (!ack_en_q && state_d != dah_pkg::WAIT_PULSE
			&& !cmd_is(cmd_ok, cmd, dah_pkg::CMD_ACK_ON))
			state_d = dah_pkg::WAIT_IDLE;
	end

	// ==========================================================
	// Wait state register
	// ==========================================================
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
			state_q <= dah_pkg::WAIT_IDLE;
		else
			state_q <= state_d;
	end

	// ==========================================================
	// Pulse width counter
	// ==========================================================
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
			cnt_q <= 5'h00;
		else if (state_q == dah_pkg::WAIT_PULSE)
			cnt_q <= cnt_q + 5'h01;
		else
			cnt_q <= 5'h00;
	end

	// ==========================================================
	// Pin and status outputs
	// ==========================================================
	// Pulse is active low; enable covers only the pulse
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			PIN_OUT     <= 1'b1;
			PIN_OE      <= 1'b0;
			ACK_ENABLED <= 1'b0;
			ACK_PENDING <= 1'b0;
		end
		else
		begin
			PIN_OE      <= (state_d == dah_pkg::WAIT_PULSE);
			PIN_OUT     <= ~(state_d == dah_pkg::WAIT_PULSE);
			ACK_ENABLED <= ack_en_q;
			ACK_PENDING <= (state_d != dah_pkg::WAIT_IDLE);
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	a_reset_disabled: assert property (@(posedge CLOCK)
		$fell(RESET) |-> !ack_en_q)
		else $error("handshake not disabled after reset");

	a_enable_answers: assert property (@(posedge CLOCK)
		disable iff (RESET)
		(cmd_ok && cmd == dah_pkg::CMD_ACK_ON
			&& state_q != dah_pkg::WAIT_PULSE) |=> PIN_OE)
		else $error("enable command gave no pulse");

	a_bus_answer: assert property (@(posedge CLOCK)
		disable iff (RESET)
		(state_q == dah_pkg::WAIT_BUS && !cmd_ok && BUS_DONE
			&& ack_en_q) |=> PIN_OE && !PIN_OUT)
		else $error("no pulse after bus cycle");

	a_no_early_ack: assert property (@(posedge CLOCK)
		disable iff (RESET)
		(state_q == dah_pkg::WAIT_BUS && !cmd_ok && !BUS_DONE)
		|=> !PIN_OE)
		else $error("pulse before bus cycle done");

	a_halt_answer: assert property (@(posedge CLOCK)
		disable iff (RESET)
		(state_q == dah_pkg::WAIT_HALT && !cmd_ok && enter_halt
			&& ack_en_q) |=> PIN_OE)
		else $error("no pulse on background entry");

	a_go_answer: assert property (@(posedge CLOCK)
		disable iff (RESET)
		(state_q == dah_pkg::WAIT_RESUME && !cmd_ok && leave_halt
			&& ack_en_q) |=> PIN_OE)
		else $error("no pulse on resume");

	a_tag_silent: assert property (@(posedge CLOCK)
		disable iff (RESET)
		(cmd_ok && cmd == dah_pkg::CMD_TAG_RUN
			&& state_q != dah_pkg::WAIT_PULSE)
		|=> !PIN_OE ##1 (!PIN_OE || $past(cmd_ok)))
		else $error("tagged run produced a pulse");

	a_sync_cancel: assert property (@(posedge CLOCK)
		disable iff (RESET)
		(cmd_ok && cmd == dah_pkg::CMD_SYNC
			&& state_q != dah_pkg::WAIT_PULSE) |=> !ACK_PENDING)
		else $error("sync did not cancel answer");

	a_drive_gated: assert property (@(posedge CLOCK)
		disable iff (RESET)
		PIN_OE && !$past(PIN_OE) |-> $past(ack_en_q)
			|| $past(cmd_ok && cmd == dah_pkg::CMD_ACK_ON))
		else $error("pin driven while handshake off");

	a_pulse_width: assert property (@(posedge CLOCK)
		disable iff (RESET)
		$rose(PIN_OE) |-> PIN_OE [*8] ##1 PIN_OE [*8] ##1 !PIN_OE)
		else $error("pulse width wrong");

	// Read and write only arm the wait; the bus decides the answer
	a_read_waits: assert property (@(posedge CLOCK)
		disable iff (RESET)
		(cmd_is(cmd_ok, cmd, dah_pkg::CMD_READ) && ack_en_q
			&& state_q != dah_pkg::WAIT_PULSE)
		|=> ACK_PENDING && !PIN_OE)
		else $error("read answered before bus cycle");

	a_write_waits: assert property (@(posedge CLOCK)
		disable iff (RESET)
		(cmd_is(cmd_ok, cmd, dah_pkg::CMD_WRITE) && ack_en_q
			&& state_q != dah_pkg::WAIT_PULSE)
		|=> ACK_PENDING && !PIN_OE)
		else $error("write answered before bus cycle");

	a_until_waits: assert property (@(posedge CLOCK)
		disable iff (RESET)
		(cmd_is(cmd_ok, cmd, dah_pkg::CMD_GO_UNTIL) && ack_en_q
			&& state_q != dah_pkg::WAIT_PULSE)
		|=> state_q == dah_pkg::WAIT_HALT && !PIN_OE)
		else $error("go-until answered too early");

	a_step_waits: assert property (@(posedge CLOCK)
		disable iff (RESET)
		(cmd_is(cmd_ok, cmd, dah_pkg::CMD_STEP) && ack_en_q
			&& state_q != dah_pkg::WAIT_PULSE)
		|=> state_q == dah_pkg::WAIT_HALT && !PIN_OE)
		else $error("step answered too early");

	// Leaving background must not answer a halt wait
	a_resume_quiet: assert property (@(posedge CLOCK)
		disable iff (RESET)
		(state_q == dah_pkg::WAIT_HALT && !cmd_ok && leave_halt)
		|=> !PIN_OE)
		else $error("answer given on resume");

	a_off_silent: assert property (@(posedge CLOCK)
		disable iff (RESET)
		(!ack_en_q && state_q != dah_pkg::WAIT_PULSE
			&& !cmd_is(cmd_ok, cmd, dah_pkg::CMD_ACK_ON))
		|=> !PIN_OE)
		else $error("pulse while handshake off");

	// Pin is only ever driven low; high comes from the pull-up
	a_pin_low: assert property (@(posedge CLOCK)
		disable iff (RESET)
		PIN_OE |-> !PIN_OUT)
		else $error("pin driven high");

	a_pin_idle: assert property (@(posedge CLOCK)
		disable iff (RESET)
		!PIN_OE |-> PIN_OUT)
		else $error("released pin not at idle level");

endmodule // dah_ack_core

`default_nettype wire

//--- shared/dah_pkg.sv
`default_nettype none

package dah_pkg;

	// ==========================================================
	// Command codes presented by the serial front end
	// ==========================================================
	typedef enum logic [3:0] {
		CMD_NONE       = 4'h0, // No command this cycle
		CMD_ACK_ON     = 4'h1, // Handshake enable
		CMD_ACK_OFF    = 4'h2, // Handshake disable
		CMD_READ       = 4'h3, // Any read command
		CMD_WRITE      = 4'h4, // Any write command
		CMD_BACKGROUND = 4'h5, // Enter background
		CMD_GO         = 4'h6, // Resume execution
		CMD_GO_UNTIL   = 4'h7, // Resume, answer on next halt
		CMD_STEP       = 4'h8, // single_step_cmd
		CMD_TAG_RUN    = 4'h9, // tagged_run_cmd
		CMD_SYNC       = 4'ha  // Sync, cancels pending answer
	} dah_cmd_t;

	// ==========================================================
	// What the block is waiting for before it answers
	// ==========================================================
	typedef enum logic [2:0] {
		WAIT_IDLE   = 3'b000, // Nothing pending
		WAIT_BUS    = 3'b001, // Internal bus cycle to finish
		WAIT_HALT   = 3'b010, // Processor to enter background
		WAIT_RESUME = 3'b011, // Processor to leave background
		WAIT_PULSE  = 3'b100  // Pulse being driven
	} dah_state_t;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int CLK_PERIOD_NS = 25;  // Core clock period
	localparam int ACK_PULSE_TC  = 16;  // Pulse width in target clocks
	localparam logic [4:0] ACK_CNT_LAST = 5'(ACK_PULSE_TC - 1);

endpackage

`default_nettype wire

//--- test/dah_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Debug host: watches the wire, counts answer pulses
// ==========================================================
module dah_host_model
(
	input  wire logic       clk,       // Core clock
	input  wire logic       rst,       // Async reset
	input  wire logic       pin_out,   // Target drive level
	input  wire logic       pin_oe,    // Target drive enable
	output var  logic       pin_in,    // Resolved wire level
	output var  logic [7:0] pulse_cnt, // Pulses seen
	output var  logic [7:0] pulse_len  // Width of last pulse
);
	logic [7:0] run_q; // Low cycles so far

	// Pull-up holds the wire high when released
	always_comb pin_in = pin_oe ? pin_out : 1'b1;

	// A missing pulse tells the host there is no handshake
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			run_q     <= 8'h00;
			pulse_cnt <= 8'h00;
			pulse_len <= 8'h00;
		end
		else if (pin_oe && !pin_out)
			run_q <= run_q + 8'h01;
		else if (run_q != 8'h00)
		begin
			pulse_cnt <= pulse_cnt + 8'h01;
			pulse_len <= run_q;
			run_q     <= 8'h00;
		end
	end
endmodule // dah_host_model
`default_nettype wire

//--- test/debug_ack_handshake_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Testbench top
// ==========================================================
module debug_ack_handshake_tb_top;
	typedef struct { dah_pkg::dah_cmd_t c; int act; int n; } dah_row_t;
	logic       clk = 1'b0;   // Core clock
	logic       rst = 1'b1;   // Reset
	logic       vld = 1'b0;   // Command strobe
	logic [3:0] code = 4'h0;  // Command code
	logic       bdone = 1'b0; // Bus cycle done
	logic       halted = 1'b0; // Processor halted
	logic       pin_in, pin_out, pin_oe, enab, pend;
	logic [7:0] cnt, len, n0;
	int         bad_count = 0;
	int         compares = 0;
	// Actions: 0 none, 1 bus done, 2 halt, 3 resume, 4 resume+halt
	dah_row_t   rows [11] = '{
		'{dah_pkg::CMD_ACK_ON, 0, 1}, '{dah_pkg::CMD_READ, 1, 1},
		'{dah_pkg::CMD_WRITE, 1, 1}, '{dah_pkg::CMD_BACKGROUND, 2, 1},
		'{dah_pkg::CMD_GO_UNTIL, 4, 1}, '{dah_pkg::CMD_STEP, 4, 1},
		'{dah_pkg::CMD_GO, 3, 1}, '{dah_pkg::CMD_TAG_RUN, 2, 0},
		'{dah_pkg::CMD_ACK_OFF, 0, 0}, '{dah_pkg::CMD_GO, 3, 0},
		'{dah_pkg::CMD_READ, 1, 0}};

	always #12.5 clk = ~clk;

	dah_ack_core i_dah_ack_core (.CLOCK(clk), .RESET(rst), .CMD_VALID(vld),
		.CMD_CODE(code), .BUS_DONE(bdone), .CPU_HALTED(halted),
		.PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
		.ACK_ENABLED(enab), .ACK_PENDING(pend));
	dah_host_model i_dah_host_model (.clk(clk), .rst(rst), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_in(pin_in), .pulse_cnt(cnt), .pulse_len(len));

	// Compare one value, report on mismatch
	task automatic check(input string nm, input logic [7:0] s, e);
	begin
		compares++;
		if (s !== e)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	end
	endtask

	task automatic end_of_test;
	begin
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask

	// One-cycle command strobe
	task automatic cmd(input dah_pkg::dah_cmd_t c);
	begin
		@(posedge clk);
		vld  <= 1'b1;
		code <= c;
		@(posedge clk);
		vld  <= 1'b0;
	end
	endtask

	// Stimulus after the command, then count answers
	task automatic run(input dah_row_t r);
	begin
		n0 = cnt;
		cmd(r.c);
		repeat (2) @(posedge clk);
		if (r.act == 1) bdone <= 1'b1;
		if (r.act == 2) halted <= 1'b1;
		if (r.act >= 3) halted <= 1'b0;
		@(posedge clk);
		bdone <= 1'b0;
		repeat (2) @(posedge clk);
		if (r.act == 4) halted <= 1'b1;
		// Fixed worst-case wait, the only option with handshake off
		repeat (40) @(posedge clk);
		check("pulses", cnt - n0, 8'(r.n));
		if (r.n != 0)
			check("width", len, 8'(dah_pkg::ACK_PULSE_TC));
	end
	endtask

	// Watchdog: whole run is about 670 cycles
	initial
	begin
		#(5000 * dah_pkg::CLK_PERIOD_NS);
		bad_count++;
		end_of_test();
	end

	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("enabled", 8'(enab), 8'h00);
		check("wire", 8'(pin_in), 8'h01);
		for (int i = 0; i < 11; i++)
			run(rows[i]);
		// Pending halt answer dropped by sync
		run(rows[0]);
		check("enabled", 8'(enab), 8'h01);
		n0 = cnt;
		cmd(dah_pkg::CMD_BACKGROUND);
		@(posedge clk);
		check("pending", 8'(pend), 8'h01);
		cmd(dah_pkg::CMD_SYNC);
		@(posedge clk);
		check("pending", 8'(pend), 8'h00);
		halted <= 1'b1;
		repeat (40) @(posedge clk);
		check("pulses", cnt - n0, 8'h00);
		// A reset mid-run turns the handshake off again
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("enabled", 8'(enab), 8'h00);
		// Read after reset must stay silent until enabled again
		run(rows[10]);
		end_of_test();
	end
endmodule // debug_ack_handshake_tb_top
`default_nettype wire
